/* File: include/bst_pkg.sv */
// package: shared constants for the boundary scan test port and its controller
package bst_pkg;
	localparam int          IR_W          = 4;
	localparam int          ID_W          = 32;
	localparam int          BSR_W         = 8;
	localparam int          RESET_TMS_N   = 5;
	localparam logic [3:0]  IR_EXTEST     = 4'h0;
	localparam logic [3:0]  IR_SKIP       = 4'hf;
	localparam logic [3:0]  IR_IDENT      = 4'hb;
	localparam logic [3:0]  IR_FLOAT      = 4'h7;
	localparam logic [3:0]  IR_CLAMP      = 4'h4;
	localparam logic [3:0]  IR_SAMPLE     = 4'h8;
	localparam logic [3:0]  IR_NONSCAN    = 4'hc;
	localparam int          ID_REV_LSB    = 28;
	localparam int          ID_PART_LSB   = 12;
	localparam int          ID_VEND_LSB   = 1;
	localparam logic [3:0]  ID_REV        = 4'h1;     // arbitrary value
	localparam logic [15:0] ID_PART       = 16'h5a5a; // arbitrary value
	localparam logic [10:0] ID_VEND       = 11'h123;  // arbitrary value
	localparam int          TCK_DIV       = 4;
	localparam logic [1:0]  CMD_SHIFT_IR  = 2'h1;
	localparam logic [1:0]  CMD_SHIFT_DR  = 2'h2;
	localparam logic [1:0]  CMD_RESET     = 2'h3;
	localparam logic [2:0]  ADR_CMD       = 3'h0;
	localparam logic [2:0]  ADR_LEN       = 3'h1;
	localparam logic [2:0]  ADR_TXD       = 3'h2;
	localparam logic [2:0]  ADR_RXD       = 3'h3;
	localparam logic [2:0]  ADR_STAT      = 3'h4;
	typedef enum logic [15:0] {
		TS_RESET = 16'h0001, TS_IDLE = 16'h0002, TS_SEL_DR = 16'h0004, TS_CAP_DR = 16'h0008,
		TS_SH_DR = 16'h0010, TS_EX1_DR = 16'h0020, TS_PAU_DR = 16'h0040, TS_EX2_DR = 16'h0080,
		TS_UPD_DR = 16'h0100, TS_SEL_IR = 16'h0200, TS_CAP_IR = 16'h0400, TS_SH_IR = 16'h0800,
		TS_EX1_IR = 16'h1000, TS_PAU_IR = 16'h2000, TS_EX2_IR = 16'h4000, TS_UPD_IR = 16'h8000
	} bst_state_t;
endpackage : bst_pkg

/* File: include/bst_if.sv */
// interface: the four scan wires between test controller and device
`timescale 1ns/1ps
interface bst_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	modport dev (input tck, input tms, input tdi, output tdo);
	modport ctl (output tck, output tms, output tdi, input tdo);
endinterface : bst_if

/* File: logic/bst_tap_fsm.sv */
// module: test port state machine with tms-high reset counter
`timescale 1ns/1ps
module bst_tap_fsm
	import bst_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       step,
	input  wire logic       tms,
	output bst_state_t      state
);
	bst_state_t state_reg;
	bst_state_t state_next;
	logic [2:0] ones_reg;
	wire        five_high = tms && (ones_reg == 3'(RESET_TMS_N - 1));
	assign state = state_reg;
	always_comb begin
		unique case (state_reg)
			TS_RESET:  state_next = tms ? TS_RESET  : TS_IDLE;
			TS_IDLE:   state_next = tms ? TS_SEL_DR : TS_IDLE;
			TS_SEL_DR: state_next = tms ? TS_SEL_IR : TS_CAP_DR;
			TS_CAP_DR: state_next = tms ? TS_EX1_DR : TS_SH_DR;
			TS_SH_DR:  state_next = tms ? TS_EX1_DR : TS_SH_DR;
			TS_EX1_DR: state_next = tms ? TS_UPD_DR : TS_PAU_DR;
			TS_PAU_DR: state_next = tms ? TS_EX2_DR : TS_PAU_DR;
			TS_EX2_DR: state_next = tms ? TS_UPD_DR : TS_SH_DR;
			TS_UPD_DR: state_next = tms ? TS_SEL_DR : TS_IDLE;
			TS_SEL_IR: state_next = tms ? TS_RESET  : TS_CAP_IR;
			TS_CAP_IR: state_next = tms ? TS_EX1_IR : TS_SH_IR;
			TS_SH_IR:  state_next = tms ? TS_EX1_IR : TS_SH_IR;
			TS_EX1_IR: state_next = tms ? TS_UPD_IR : TS_PAU_IR;
			TS_PAU_IR: state_next = tms ? TS_EX2_IR : TS_PAU_IR;
			TS_EX2_IR: state_next = tms ? TS_UPD_IR : TS_SH_IR;
			TS_UPD_IR: state_next = tms ? TS_SEL_DR : TS_IDLE;
			default:   state_next = TS_RESET;
		endcase
		if (five_high)
			state_next = TS_RESET; // [RL1]
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= TS_RESET;
			ones_reg  <= 3'h0;
		end else if (step) begin
			state_reg <= state_next;
			ones_reg  <= tms ? (five_high ? ones_reg : ones_reg + 3'h1) : 3'h0; // [RL1]
		end
	end
endmodule : bst_tap_fsm

/* File: logic/bst_device.sv */
// module: device end of the boundary scan test port
`timescale 1ns/1ps
// Behaviour
// RL1: five tck rises with tms high reset
// RL2: port reset leaves memory logic untouched
// RL3: system applies master reset after power up
// RL4: pause then shift repeats last bit
// RL5: controller avoids the data pause state
// RL6: id fields revision, part, vendor
// RL7: id bit zero reads one
// RL8: 0000 captures pins, boundary chain path
// RL9: 1111 selects one-bit skip register
// RL10: 1011 loads and shifts identification
// RL11: 0111 floats outputs, skip path
// RL12: 0100 drives outputs from cells, skip path
// RL13: 1000 samples pins, boundary chain path
// RL14: 1100 resets non-scan logic, skip path
// RL15: controller uses only listed codes
// RL16: three scan inputs, one scan output
// RL17: port reset selects identification code
module bst_device
	import bst_pkg::*;
(
	input  wire logic             SYS_CLK,
	input  wire logic             ARST_N,
	bst_if.dev                    LINK,
	input  wire logic [BSR_W-1:0] PIN_IN,
	input  wire logic [BSR_W-1:0] CORE_OUT,
	output logic      [BSR_W-1:0] PIN_OUT,
	output logic                  PIN_FLOAT,
	output logic                  NONSCAN_RESET,
	output logic [IR_W-1:0]       INSTR
);
	// link pins come from another domain, so two flops each before use
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic       tck_d_reg;
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s1_reg    <= 3'h0;
			s2_reg    <= 3'h0;
			tck_d_reg <= 1'b0;
		end else begin
			s1_reg    <= {LINK.tck, LINK.tms, LINK.tdi}; // [RL16]
			s2_reg    <= s1_reg;
			tck_d_reg <= s2_reg[2];
		end
	end
	wire tck_s = s2_reg[2];
	wire tms_s = s2_reg[1];
	wire tdi_s = s2_reg[0];
	wire rise  = tck_s && !tck_d_reg;
	wire fall  = !tck_s && tck_d_reg;

	bst_state_t st;
	bst_tap_fsm u_fsm (
		.clk    (SYS_CLK),
		.arst_n (ARST_N),
		.step   (rise),
		.tms    (tms_s),
		.state  (st)
	);

	logic [IR_W-1:0]  ir_reg;
	logic [IR_W-1:0]  irsh_reg;
	logic             skip_reg;
	logic [ID_W-1:0]  id_reg;
	logic [BSR_W-1:0] chain_reg;
	logic [BSR_W-1:0] upd_reg;
	logic             tdo_reg;
	logic             dup_reg;
	logic [BSR_W-1:0] pin_out_reg;
	logic             float_reg;
	logic             nrst_reg;

	wire [ID_W-1:0] id_code = {ID_REV, ID_PART, ID_VEND, 1'b1}; // [RL6] [RL7]
	wire use_chain = (ir_reg == IR_EXTEST) || (ir_reg == IR_SAMPLE); // [RL8] [RL13]
	wire use_id    = (ir_reg == IR_IDENT); // [RL10]
	wire in_reset  = (st == TS_RESET);
	wire cap_dr    = (st == TS_CAP_DR);
	wire sh_dr     = (st == TS_SH_DR);
	wire dr_lsb    = use_chain ? chain_reg[0] : (use_id ? id_reg[0] : skip_reg); // [RL9]
	// pause re-entry repeats the last bit once; kept to match the part
	wire dr_out    = dup_reg ? tdo_reg : dr_lsb; // [RL4]
	wire out_bit   = (st == TS_SH_IR) ? irsh_reg[0] : dr_out;

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			irsh_reg <= 4'h0;
			skip_reg <= 1'b0;
			id_reg   <= 32'h0;
			dup_reg  <= 1'b0;
		end else if (rise) begin
			if (st == TS_CAP_IR)
				irsh_reg <= 4'h1;
			else if (st == TS_SH_IR)
				irsh_reg <= {tdi_s, irsh_reg[IR_W-1:1]};
			if (cap_dr)
				skip_reg <= 1'b0;
			else if (sh_dr)
				skip_reg <= tdi_s;
			if (cap_dr && use_id)
				id_reg <= id_code; // [RL10]
			else if (sh_dr && use_id)
				id_reg <= {tdi_s, id_reg[ID_W-1:1]};
			dup_reg <= (st == TS_EX2_DR) && !tms_s; // [RL4]
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			chain_reg <= 8'h0;
			upd_reg   <= 8'h0;
		end else if (rise) begin
			if (cap_dr && use_chain)
				chain_reg <= PIN_IN; // [RL8] [RL13]
			else if (sh_dr && use_chain && !dup_reg)
				chain_reg <= {tdi_s, chain_reg[BSR_W-1:1]};
			if (st == TS_UPD_DR && use_chain)
				upd_reg <= chain_reg;
		end
	end

	// reset state forces the id code at once, no extra tck rise is needed
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			ir_reg <= IR_IDENT;
		else if (in_reset)
			ir_reg <= IR_IDENT; // [RL17]
		else if (rise && st == TS_UPD_IR)
			ir_reg <= irsh_reg;
	end

	// scan output changes on falling tck
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			tdo_reg <= 1'b0;
		else if (fall)
			tdo_reg <= out_bit;
	end
	assign LINK.tdo = tdo_reg;

	// outputs touch the pins and the non-scan reset line; memory state is never reset by the port
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pin_out_reg <= 8'h0;
			float_reg   <= 1'b0;
			nrst_reg    <= 1'b0;
		end else begin
			pin_out_reg <= (ir_reg == IR_CLAMP || ir_reg == IR_EXTEST) ? upd_reg : CORE_OUT; // [RL12] [RL2]
			float_reg   <= (ir_reg == IR_FLOAT); // [RL11]
			nrst_reg    <= (ir_reg == IR_NONSCAN); // [RL14]
		end
	end
	assign PIN_OUT       = pin_out_reg;
	assign PIN_FLOAT     = float_reg;
	assign NONSCAN_RESET = nrst_reg;
	assign INSTR         = ir_reg;
endmodule : bst_device

/* File: logic/bst_controller.sv */
// module: test controller end, driven by software over a plain register port
`timescale 1ns/1ps
module bst_controller
	import bst_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        ARST_N,
	bst_if.ctl               LINK,
	input  wire logic [2:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA
);
	logic [1:0]  div_reg;
	logic        tck_reg;
	logic        tms_reg;
	logic        tdi_reg;
	logic [1:0]  cmd_reg;
	logic [5:0]  len_reg;
	logic [5:0]  cnt_reg;
	logic [2:0]  ph_reg;
	logic [31:0] txd_reg;
	logic [31:0] rxd_reg;
	logic [31:0] rdata_reg;
	logic        busy_reg;
	logic        tdo1_reg;
	logic        tdo2_reg;
	// pattern: tms sequence from idle to shift and back, never via pause [RL5]
	wire         tick  = (div_reg == 2'(TCK_DIV - 1));
	wire         start = WR && (ADDR == ADR_CMD) && !busy_reg;
	wire         lo    = tick && tck_reg;
	wire         hi    = tick && !tck_reg;
	wire [31:0]  rmux  = (ADDR == ADR_RXD) ? rxd_reg :
	                     (ADDR == ADR_STAT) ? {31'h0, busy_reg} :
	                     (ADDR == ADR_LEN) ? {26'h0, len_reg} : 32'h0;
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tdo1_reg <= 1'b0;
			tdo2_reg <= 1'b0;
			div_reg  <= 2'h0;
			rdata_reg <= 32'h0;
		end else begin
			tdo1_reg <= LINK.tdo;
			tdo2_reg <= tdo1_reg;
			div_reg  <= tick ? 2'h0 : div_reg + 2'h1;
			rdata_reg <= RD ? rmux : 32'h0;
		end
	end
	// phases: 0 idle,1 sel-dr,2 sel-ir,3 capture,4 shift,5 exit1,6 update,7 back to idle
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tck_reg <= 1'b0;
			tms_reg <= 1'b0;
			tdi_reg <= 1'b0;
			cmd_reg <= 2'h0;
			len_reg <= 6'h20;
			cnt_reg <= 6'h0;
			ph_reg  <= 3'h0;
			txd_reg <= 32'h0;
			rxd_reg <= 32'h0;
			busy_reg <= 1'b0;
		end else begin
			if (WR && ADDR == ADR_LEN)
				len_reg <= WDATA[5:0];
			if (WR && ADDR == ADR_TXD && !busy_reg)
				txd_reg <= WDATA;
			if (start) begin
				cmd_reg  <= WDATA[1:0];
				busy_reg <= (WDATA[1:0] != 2'h0);
				ph_reg   <= 3'h0;
				cnt_reg  <= (WDATA[1:0] == CMD_RESET) ? 6'(RESET_TMS_N) : len_reg;
			end else if (tick && busy_reg) begin
				tck_reg <= !tck_reg;
				// tdo returns one tck late through both synchronisers, so sample on the next fall
				if (lo && ((ph_reg == 3'h4 && cnt_reg != len_reg) || ph_reg == 3'h5)) begin
					rxd_reg <= {tdo2_reg, rxd_reg[31:1]};
				end
				if (lo) begin
					if (cmd_reg == CMD_RESET) begin
						tms_reg <= 1'b1;
						cnt_reg <= cnt_reg - 6'h1;
						if (cnt_reg == 6'h0) begin
							tms_reg  <= 1'b0;
							busy_reg <= 1'b0;
						end
					end else begin
						unique case (ph_reg)
							3'h0: begin tms_reg <= 1'b1; ph_reg <= (cmd_reg == CMD_SHIFT_IR) ? 3'h1 : 3'h2; end
							3'h1: begin tms_reg <= 1'b1; ph_reg <= 3'h2; end
							3'h2: begin tms_reg <= 1'b0; ph_reg <= 3'h3; end
							3'h3: begin tms_reg <= 1'b0; ph_reg <= 3'h4; end
							3'h4: begin
								tdi_reg <= txd_reg[0];
								txd_reg <= {1'b0, txd_reg[31:1]};
								cnt_reg <= cnt_reg - 6'h1;
								if (cnt_reg == 6'h1) begin
									tms_reg <= 1'b1;
									ph_reg  <= 3'h5;
								end
							end
							3'h5: begin tms_reg <= 1'b1; ph_reg <= 3'h6; end
							3'h6: begin tms_reg <= 1'b0; ph_reg <= 3'h7; end
							default: begin busy_reg <= 1'b0; ph_reg <= 3'h0; end
						endcase
					end
				end
			end
		end
	end
	assign LINK.tck = tck_reg;
	assign LINK.tms = tms_reg;
	assign LINK.tdi = tdi_reg;
	assign RDATA    = rdata_reg;
endmodule : bst_controller

/* File: dv/bst_link_checker.sv */
// checker: timing relations on the four scan wires
`timescale 1ns/1ps
module bst_link_checker (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	a_tck_high_len: assert property ($rose(tck) |=> tck[*3] ##1 !tck)
		else $error("link clock high time wrong");
	a_tck_low_len: assert property ($fell(tck) |=> !tck[*3])
		else $error("link clock low time too short");
	a_tms_moves_low: assert property ($changed(tms) |-> !tck)
		else $error("mode select moved while clock high");
	a_tms_held_high: assert property ($rose(tck) |-> ($stable(tms) throughout tck[*4]))
		else $error("mode select unstable across high phase");
	a_tdi_moves_low: assert property ($changed(tdi) |-> !tck)
		else $error("serial input moved while clock high");
	a_tdi_held_high: assert property ($rose(tck) |-> $stable(tdi)[*4])
		else $error("serial input unstable across high phase");
	a_tdo_after_fall: assert property ($changed(tdo) |-> !$past(tck, 2))
		else $error("serial output moved away from falling edge");
	a_tdo_held_high: assert property ($rose(tck) |-> ##1 $stable(tdo)[*3])
		else $error("serial output moved while clock high");
endmodule : bst_link_checker

/* File: dv/boundary_scan_test_port_bench.sv */
// testbench: controller and device joined over the scan link
`timescale 1ns/1ps
module boundary_scan_test_port_bench;
	import bst_pkg::*;
	logic             sys_clk = 1'b0;
	logic             arst_n = 1'b0;
	logic [2:0]       addr = 3'h0;
	logic [31:0]      wdata = 32'h0;
	logic             wr = 1'b0;
	logic             rd = 1'b0;
	logic [31:0]      rdata;
	logic [BSR_W-1:0] pin_in = 8'ha5;
	logic [BSR_W-1:0] core_out = 8'h00;
	logic [BSR_W-1:0] pin_out;
	logic             pin_float;
	logic             nonscan_reset;
	logic [IR_W-1:0]  instr;
	logic [32:0]      notes[$];
	logic [32:0]      note;
	logic             rd_seen = 1'b0;
	logic [31:0]      txd;
	logic [3:0]       code;
	logic [3:0]       codes[8] = '{IR_EXTEST, IR_SKIP, IR_IDENT, IR_FLOAT, IR_CLAMP, IR_SAMPLE, IR_NONSCAN, IR_SKIP};
	integer           seed = 32'hb46c;
	int               mismatches = 0;
	int               compares = 0;
	int               cycles = 0;

	bst_if link();
	bst_device i_bst_device (.SYS_CLK(sys_clk), .ARST_N(arst_n), .LINK(link), .PIN_IN(pin_in),
		.CORE_OUT(core_out), .PIN_OUT(pin_out), .PIN_FLOAT(pin_float), .NONSCAN_RESET(nonscan_reset), .INSTR(instr));
	bst_controller i_bst_controller (.SYS_CLK(sys_clk), .ARST_N(arst_n), .LINK(link), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
	bst_link_checker i_bst_link_checker (.SYS_CLK(sys_clk), .ARST_N(arst_n), .tck(link.tck), .tms(link.tms),
		.tdi(link.tdi), .tdo(link.tdo));

	always #20 sys_clk = ~sys_clk;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task close_out;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	task wr_reg(input logic [2:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wr_reg

	// chk low marks a status poll whose value is not judged
	task rd_reg(input logic [2:0] a, input logic chk, input logic [31:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		notes.push_back({chk, exp});
		@(posedge sys_clk);
		rd <= 1'b0;
	endtask : rd_reg

	// extra cycles cover the device's input synchroniser lag
	task scan(input logic [1:0] cmd, input logic [31:0] len, input logic [31:0] d);
		logic busy;
		busy = 1'b1;
		wr_reg(ADR_LEN, len);
		wr_reg(ADR_TXD, d);
		wr_reg(ADR_CMD, {30'h0, cmd});
		repeat (2) @(posedge sys_clk);
		while (busy === 1'b1) begin
			rd_reg(ADR_STAT, 1'b0, 32'h0);
			@(negedge sys_clk);
			busy = rdata[0];
		end
		repeat (8) @(posedge sys_clk);
	endtask : scan

	// chain holds pins a5, a palindrome, so cell order does not matter
	function automatic logic [31:0] dr_exp(input logic [3:0] c, input logic [31:0] t);
		if (c == IR_IDENT) return {ID_REV, ID_PART, ID_VEND, 1'b1};
		if (c == IR_EXTEST || c == IR_SAMPLE) return {t[23:0], 8'ha5};
		return {t[30:0], 1'b0};
	endfunction : dr_exp

	always @(posedge sys_clk) rd_seen <= rd;
	always @(negedge sys_clk) begin
		if (rd_seen) begin
			note = notes.pop_front();
			if (note[32]) check(rdata, note[31:0]);
		end
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			close_out();
		end
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd_reg(3'h5, 1'b1, 32'h0);
		rd_reg(3'h7, 1'b1, 32'h0);
		$display("test unmapped done");
		for (int i = 0; i < 9; i++) begin
			code = (i < 8) ? codes[i] : IR_IDENT;
			core_out <= 8'($random(seed));
			if (i < 8) scan(CMD_SHIFT_IR, 32'd4, {28'h0, code});
			else scan(CMD_RESET, 32'd0, 32'h0);
			check(32'(instr), 32'(code));
			check(32'(pin_float), 32'(code == IR_FLOAT));
			check(32'(nonscan_reset), 32'(code == IR_NONSCAN));
			if (code != IR_EXTEST && code != IR_CLAMP) check(32'(pin_out), 32'(core_out));
			txd = $random(seed);
			scan(CMD_SHIFT_DR, 32'd32, txd);
			rd_reg(ADR_RXD, 1'b1, dr_exp(code, txd));
			$display("test code %h done", code);
		end
		repeat (4) @(posedge sys_clk);
		close_out();
	end
endmodule : boundary_scan_test_port_bench
